// ---- src/adc_result_compare_config_regs.sv ----
// Result, compare value, configuration and pin-control registers of the converter.
// Assumes a converter core pulsing done with a 12-bit result, and a CPU register port.
`timescale 1ns/100ps
module adc_result_compare_config_regs
    import adc_regs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        write_i,
    input  wire logic        read_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        conv_done_i,
    input  wire logic [11:0] conv_result_i,
    input  wire logic        compare_function_enable_i,
    input  wire logic        compare_greater_i,
    input  wire logic        single_mode_i,
    output logic             result_stored_o,
    output logic             restart_conv_o,
    output logic             result_valid_o,
    output logic             low_power_select_o,
    output logic      [1:0]  clock_divide_select_o,
    output logic             long_sample_select_o,
    output logic      [1:0]  mode_o,
    output logic      [1:0]  input_clock_select_o,
    input  wire logic [15:0] port_out_en_i,
    input  wire logic [15:0] port_pullup_i,
    input  wire logic [15:0] pin_in_i,
    output logic      [15:0] pin_out_en_o,
    output logic      [15:0] pin_pullup_o,
    output logic      [15:0] port_in_o
);

    // ********************************************************
    // Storage
    // ********************************************************
    logic [7:0]  result_high_reg;
    logic [7:0]  result_low_byte_reg;
    logic [7:0]  compare_value_high_reg;
    logic [7:0]  compare_value_low_reg;
    logic [7:0]  converter_configuration_reg;
    logic [7:0]  analog_pin_select_lo_reg;
    logic [7:0]  analog_pin_select_mid_reg;
    logic        interlock_reg;
    logic        valid_reg;
    logic        stored_reg;
    logic        restart_reg;
    logic [7:0]  rdata_reg;
    logic [15:0] out_en_reg;
    logic [15:0] pullup_reg;
    logic [15:0] port_in_reg;

    logic [1:0]  mode;
    logic [11:0] diff;
    logic        hit;
    logic        accept;
    logic        blocked;
    logic [11:0] stored_value;
    logic        mode_change;
    logic [15:0] out_en_w;
    logic [15:0] pullup_w;
    logic [15:0] port_in_w;

    function automatic logic is_wide(input logic [1:0] m);
        return (m == MODE_12BIT) || (m == MODE_10BIT);
    endfunction

    function automatic logic hit_wr(input logic [3:0] a, input logic [3:0] ofs,
                                    input logic w);
        return w && (a == ofs);
    endfunction

    assign mode = converter_configuration_reg[CFG_MODE_POS +: 2];

    // ********************************************************
    // Compare and pins
    // ********************************************************
    adc_compare_unit u_compare (
        .result_i   (conv_result_i),
        .cmp_high_i (compare_value_high_reg),
        .cmp_low_i  (compare_value_low_reg),
        .mode_i     (mode),
        .greater_i  (compare_greater_i),
        .diff_o     (diff),
        .hit_o      (hit)
    );

    adc_pin_gate u_pins (
        .select_i      ({analog_pin_select_mid_reg, analog_pin_select_lo_reg}),
        .port_out_en_i (port_out_en_i),
        .port_pullup_i (port_pullup_i),
        .pin_in_i      (pin_in_i),
        .out_en_o      (out_en_w),
        .pullup_o      (pullup_w),
        .port_in_o     (port_in_w)
    );

    // ********************************************************
    // Result transfer decision
    // ********************************************************
    // Interlock only matters in wide modes; a pending low read drops the result
    assign blocked = interlock_reg && is_wide(mode);
    assign accept  = conv_done_i && !blocked
                   && (!compare_function_enable_i || hit);
    assign stored_value = compare_function_enable_i ? diff : conv_result_i;
    assign mode_change = hit_wr(addr_i, OFS_CONFIG, write_i)
                       && (wdata_i[CFG_MODE_POS +: 2] != mode);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            result_high_reg     <= REG_RESET;
            result_low_byte_reg <= REG_RESET;
        end else if (accept) begin
            unique case (mode)
                MODE_12BIT: result_high_reg <= {4'h0, stored_value[11:8]};
                MODE_10BIT: result_high_reg <= {6'h00, stored_value[9:8]};
                default:    result_high_reg <= REG_RESET;
            endcase
            result_low_byte_reg <= stored_value[7:0];
        end
    end

    // Valid flag: a new store wins over an invalidating mode write
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            valid_reg <= 1'b0;
        end else if (accept) begin
            valid_reg <= 1'b1;
        end else if (mode_change) begin
            valid_reg <= 1'b0;
        end
    end

    // Interlock: set by high read in 12/10-bit modes, cleared by low read; set wins
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            interlock_reg <= 1'b0;
        end else if (read_i && addr_i == OFS_RESULT_HIGH && is_wide(mode)) begin
            interlock_reg <= 1'b1;
        end else if (read_i && addr_i == OFS_RESULT_LOW) begin
            interlock_reg <= 1'b0;
        end
    end

    // Completion and restart pulses toward the sequencer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            stored_reg  <= 1'b0;
            restart_reg <= 1'b0;
        end else begin
            stored_reg  <= accept;
            // Blocked single compare-miss just ends; other blocked cases retry
            restart_reg <= conv_done_i && blocked
                         && !(single_mode_i && compare_function_enable_i && !hit);
        end
    end

    // ********************************************************
    // Software registers
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            compare_value_high_reg      <= REG_RESET;
            compare_value_low_reg       <= REG_RESET;
            converter_configuration_reg <= REG_RESET;
            analog_pin_select_lo_reg    <= REG_RESET;
            analog_pin_select_mid_reg   <= REG_RESET;
        end else if (write_i) begin
            unique case (addr_i)
                OFS_CMP_HIGH: compare_value_high_reg      <= wdata_i;
                OFS_CMP_LOW:  compare_value_low_reg       <= wdata_i;
                OFS_CONFIG:   converter_configuration_reg <= wdata_i;
                OFS_PIN_LO:   analog_pin_select_lo_reg    <= wdata_i;
                OFS_PIN_MID:  analog_pin_select_mid_reg   <= wdata_i;
                default: ;
            endcase
        end
    end

    // Unmapped addresses and either result byte while invalid read zero
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_reg <= REG_RESET;
        end else if (read_i) begin
            unique case (addr_i)
                OFS_RESULT_HIGH: rdata_reg <= valid_reg ? result_high_reg : REG_RESET;
                OFS_RESULT_LOW:  rdata_reg <= valid_reg ? result_low_byte_reg : REG_RESET;
                OFS_CMP_HIGH:    rdata_reg <= compare_value_high_reg;
                OFS_CMP_LOW:     rdata_reg <= compare_value_low_reg;
                OFS_CONFIG:      rdata_reg <= converter_configuration_reg;
                OFS_PIN_LO:      rdata_reg <= analog_pin_select_lo_reg;
                OFS_PIN_MID:     rdata_reg <= analog_pin_select_mid_reg;
                default:         rdata_reg <= REG_RESET;
            endcase
        end else begin
            rdata_reg <= REG_RESET;
        end
    end

    // Pin gating registered so every output leaves a flop; one cycle of lag
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            out_en_reg  <= 16'h0000;
            pullup_reg  <= 16'h0000;
            port_in_reg <= 16'h0000;
        end else begin
            out_en_reg  <= out_en_w;
            pullup_reg  <= pullup_w;
            port_in_reg <= port_in_w;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign rdata_o               = rdata_reg;
    assign result_stored_o       = stored_reg;
    assign restart_conv_o        = restart_reg;
    assign result_valid_o        = valid_reg;
    assign low_power_select_o    = converter_configuration_reg[CFG_LOW_POWER_POS];
    assign clock_divide_select_o = converter_configuration_reg[CFG_DIVIDE_POS +: 2];
    assign long_sample_select_o  = converter_configuration_reg[CFG_LONG_SMP_POS];
    assign mode_o                = mode;
    assign input_clock_select_o  = converter_configuration_reg[CFG_CLKSEL_POS +: 2];
    assign pin_out_en_o          = out_en_reg;
    assign pin_pullup_o          = pullup_reg;
    assign port_in_o             = port_in_reg;

endmodule

// ---- src/adc_regs_pkg.sv ----
// Constants, register map and field layout of the converter result/config register block.
// Assumes a plain synchronous register port on a 10 MHz bus clock.
// Function
// - Low result byte holds result bits 7:0, or all of an 8-bit result.
// - Load result at every completion unless compare enabled and condition false.
// - On compare event store conversion result plus two's complement of compare value.
// - In 12/10-bit modes a high-byte read blocks transfers until low byte read.
// - A result finishing while the low byte is unread is discarded.
// - In 8-bit mode high-byte reads never block transfers.
// - A write changing the mode field invalidates the low result byte.
// - 12-bit compare uses four compare-high bits against upper result bits.
// - 10-bit compare uses two compare-high bits against upper two result bits.
// - 8-bit compare ignores the compare-high register.
// - Compare-low bits are compared with the lower eight result bits always.
// - Configuration bit 7 selects high-speed or low-power converter operation.
// - Configuration bits 6:5 divide the input clock by 1, 2, 4 or 8.
// - Configuration bit 4 selects short or long sample time.
// - Configuration bits 3:2 select 8, 12 or 10-bit; 11 reserved.
// - Configuration bits 1:0 select bus, bus/2, alternate or internal async clock.
// - First pin-control bit n takes channel n pin away from port logic.
// - Second pin-control bit n takes channel n+8 pin away from port logic.
// - A set pin bit tristates output, kills input buffer and pullup.
// - A blocked transfer sets no completion flag and the result is lost.
package adc_regs_pkg;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [3:0] OFS_RESULT_HIGH  = 4'h0;
    localparam logic [3:0] OFS_RESULT_LOW   = 4'h1;
    localparam logic [3:0] OFS_CMP_HIGH     = 4'h2;
    localparam logic [3:0] OFS_CMP_LOW      = 4'h3;
    localparam logic [3:0] OFS_CONFIG       = 4'h4;
    localparam logic [3:0] OFS_PIN_LO       = 4'h5;
    localparam logic [3:0] OFS_PIN_MID      = 4'h6;

    // ********************************************************
    // Configuration fields
    // ********************************************************
    localparam int CFG_LOW_POWER_POS  = 7;
    localparam int CFG_DIVIDE_POS     = 5;
    localparam int CFG_LONG_SMP_POS   = 4;
    localparam int CFG_MODE_POS       = 2;
    localparam int CFG_CLKSEL_POS     = 0;

    localparam logic [1:0] MODE_8BIT  = 2'h0;
    localparam logic [1:0] MODE_12BIT = 2'h1;
    localparam logic [1:0] MODE_10BIT = 2'h2;

    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [3:0] CMP_HI12_MASK = 4'hf;
    localparam logic [3:0] CMP_HI10_MASK = 4'h3;

endpackage

// ---- src/adc_compare_unit.sv ----
// Compare value alignment and difference for the result path.
// Assumes a result already aligned to the selected resolution.
`timescale 1ns/100ps
module adc_compare_unit
    import adc_regs_pkg::*;
(
    input  wire logic [11:0] result_i,
    input  wire logic [7:0]  cmp_high_i,
    input  wire logic [7:0]  cmp_low_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic        greater_i,
    output logic      [11:0] diff_o,
    output logic             hit_o
);
    logic [11:0] cmp_value;
    logic [11:0] res_masked;

    always_comb begin
        unique case (mode_i)
            MODE_12BIT: begin
                cmp_value  = {cmp_high_i[3:0] & CMP_HI12_MASK, cmp_low_i};
                res_masked = result_i;
            end
            MODE_10BIT: begin
                cmp_value  = {cmp_high_i[3:0] & CMP_HI10_MASK, cmp_low_i};
                res_masked = {2'h0, result_i[9:0]};
            end
            default: begin
                cmp_value  = {4'h0, cmp_low_i};
                res_masked = {4'h0, result_i[7:0]};
            end
        endcase
        diff_o = res_masked + (~cmp_value + 12'h001);
        hit_o  = greater_i ? (res_masked >= cmp_value) : (res_masked < cmp_value);
    end
endmodule

// ---- src/adc_pin_gate.sv ----
// Per-pin gating of port logic by the analog pin select bits.
// Assumes port logic drives output, enable, pullup and samples input per pin.
`timescale 1ns/100ps
module adc_pin_gate (
    input  wire logic [15:0] select_i,
    input  wire logic [15:0] port_out_en_i,
    input  wire logic [15:0] port_pullup_i,
    input  wire logic [15:0] pin_in_i,
    output logic      [15:0] out_en_o,
    output logic      [15:0] pullup_o,
    output logic      [15:0] port_in_o
);
    always_comb begin
        out_en_o  = port_out_en_i & ~select_i;
        pullup_o  = port_pullup_i & ~select_i;
        port_in_o = pin_in_i & ~select_i;
    end
endmodule

// ---- bench/adc_regs_props.sv ----
// Checker of the converter register block, port behaviour only.
// Assumes binding onto the register block top module.
`timescale 1ns/100ps
module adc_regs_props
    import adc_regs_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic [3:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        write_i,
    input wire logic        read_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        conv_done_i,
    input wire logic        compare_function_enable_i,
    input wire logic        result_stored_o,
    input wire logic        restart_conv_o,
    input wire logic        result_valid_o,
    input wire logic        low_power_select_o,
    input wire logic [1:0]  mode_o,
    input wire logic [15:0] port_out_en_i,
    input wire logic [15:0] pin_out_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // ************************************************
    // Shadow of the pin select bits
    // ************************************************
    logic [15:0] sel_reg;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sel_reg <= 16'h0000;
        end else if (write_i && addr_i == OFS_PIN_LO) begin
            sel_reg[7:0] <= wdata_i;
        end else if (write_i && addr_i == OFS_PIN_MID) begin
            sel_reg[15:8] <= wdata_i;
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    chk_store_cause: assert property (
        result_stored_o |-> $past(conv_done_i) && result_valid_o)
        else $error("store pulse without completion");
    chk_free_store: assert property (
        conv_done_i && !compare_function_enable_i && mode_o == MODE_8BIT |=> result_stored_o)
        else $error("completion not stored");
    chk_blocked_lost: assert property (
        restart_conv_o |-> !result_stored_o && $past(conv_done_i))
        else $error("blocked result stored");
    chk_byte_mode_free: assert property (
        conv_done_i && mode_o == MODE_8BIT |=> !restart_conv_o)
        else $error("blocking in 8-bit mode");
    chk_cfg_write: assert property (
        $past(write_i && addr_i == OFS_CONFIG) |->
            {low_power_select_o, mode_o} == {$past(wdata_i[7]), $past(wdata_i[3:2])})
        else $error("config fields not loaded");
    chk_mode_clear: assert property (
        $past(write_i && addr_i == OFS_CONFIG && wdata_i[3:2] != mode_o && !conv_done_i)
            |-> !result_valid_o)
        else $error("valid kept after mode change");
    chk_invalid_read: assert property (
        $past(read_i && addr_i == OFS_RESULT_LOW && !result_valid_o) |-> rdata_o == 8'h00)
        else $error("invalid result byte read nonzero");
    chk_pin_tristate: assert property (
        $stable(sel_reg) && $past(resetn_i) |->
            pin_out_en_o == ($past(port_out_en_i) & ~sel_reg))
        else $error("selected pin still driven");

    cov_blocked: cover property (restart_conv_o);
    cov_cmp_store: cover property (result_stored_o && compare_function_enable_i);
    cov_mode_clear: cover property ($fell(result_valid_o));
endmodule

bind adc_result_compare_config_regs adc_regs_props chk (.clk_i, .resetn_i, .addr_i,
    .wdata_i, .write_i, .read_i, .rdata_o, .conv_done_i, .compare_function_enable_i,
    .result_stored_o, .restart_conv_o, .result_valid_o, .low_power_select_o, .mode_o,
    .port_out_en_i, .pin_out_en_o);

// ---- bench/adc_core_model.sv ----
// Behavioural converter core: pulses completion with a result after a delay.
// Assumes a one-cycle start request from the bench.
`timescale 1ns/100ps
module adc_core_model (
    input  wire logic        clk_i,
    input  wire logic        start_i,
    input  wire logic [11:0] value_i,
    input  wire logic [3:0]  delay_i,
    output logic             done_o,
    output logic      [11:0] result_o
);
    int          cnt;
    logic [11:0] hold;
    initial begin
        cnt = 0;
        hold = 12'h000;
        done_o = 1'b0;
        result_o = 12'hfff;
    end
    // Result line never rests on the last value, so stale capture shows
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        result_o <= ~hold;
        if (start_i) begin
            hold <= value_i;
            cnt <= int'(delay_i) + 1;
        end else if (cnt == 1) begin
            done_o <= 1'b1;
            result_o <= hold;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the converter register block.
// Assumes the converter core model and the bound checker.
`timescale 1ns/100ps
module tb_top
    import adc_regs_pkg::*;
;
    logic clk_i, resetn_i, write_i, read_i, conv_done_i, go, rd_d;
    logic compare_function_enable_i, compare_greater_i, single_mode_i;
    logic result_stored_o, restart_conv_o, result_valid_o, low_power_select_o;
    logic long_sample_select_o;
    logic [1:0] clock_divide_select_o, mode_o, input_clock_select_o;
    logic [3:0] addr_i, dly;
    logic [7:0] wdata_i, rdata_o, v, w;
    logic [11:0] conv_result_i, val;
    logic [15:0] port_out_en_i, port_pullup_i, pin_in_i, pin_out_en_o, pin_pullup_o, port_in_o;
    logic [7:0] rq[$];
    int err_total, comparisons, seed, i, st_cnt, rs_cnt, cycles;

    adc_result_compare_config_regs dut (.clk_i, .resetn_i, .addr_i, .wdata_i, .write_i,
        .read_i, .rdata_o, .conv_done_i, .conv_result_i, .compare_function_enable_i,
        .compare_greater_i, .single_mode_i, .result_stored_o, .restart_conv_o,
        .result_valid_o, .low_power_select_o, .clock_divide_select_o, .long_sample_select_o,
        .mode_o, .input_clock_select_o, .port_out_en_i, .port_pullup_i, .pin_in_i,
        .pin_out_en_o, .pin_pullup_o, .port_in_o);
    adc_core_model core (.clk_i, .start_i(go), .value_i(val), .delay_i(dly),
        .done_o(conv_done_i), .result_o(conv_result_i));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ************************************************
    // Tasks
    // ************************************************
    task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        write_i <= 1'b1; addr_i <= a; wdata_i <= d;
        @(posedge clk_i);
        write_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        read_i <= 1'b1; addr_i <= a; rq.push_back(e);
        @(posedge clk_i);
        read_i <= 1'b0;
    endtask
    task automatic conv(input logic [11:0] r);
        int k;
        @(posedge clk_i);
        go <= 1'b1; val <= r; dly <= 4'($random(seed));
        @(posedge clk_i);
        go <= 1'b0;
        // Looked at mid-cycle so the model's pulse has settled
        for (k = 0; k < 20 && conv_done_i !== 1'b1; k++) @(negedge clk_i);
        chkv({15'h0000, conv_done_i}, 16'h0001);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic stop_test;
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************
    // Monitor and watchdog
    // ************************************************
    always @(posedge clk_i) begin
        rd_d <= read_i;
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            stop_test();
        end
    end
    always @(negedge clk_i) begin
        if (result_stored_o === 1'b1) st_cnt++;
        if (restart_conv_o === 1'b1) rs_cnt++;
        if (rd_d === 1'b1) chkv({8'h00, rdata_o}, {8'h00, rq.pop_front()});
    end

    // ************************************************
    // Scenarios
    // ************************************************
    initial begin
        seed = 92;
        {write_i, read_i, go, rd_d, compare_function_enable_i, compare_greater_i} = '0;
        {single_mode_i, addr_i, wdata_i, val, dly, resetn_i} = '0;
        {port_out_en_i, port_pullup_i, pin_in_i} = '0;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (i = 0; i < 8; i++) rd(4'(i), 8'h00);
        for (i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            wr(OFS_CONFIG, v);
            @(negedge clk_i);
            chkv({8'h00, low_power_select_o, clock_divide_select_o, long_sample_select_o,
                  mode_o, input_clock_select_o}, {8'h00, v});
            rd(OFS_CONFIG, v);
        end
        for (i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            w = 8'($random(seed));
            wr(OFS_PIN_LO, v);
            wr(OFS_PIN_MID, w);
            port_out_en_i <= 16'($random(seed));
            port_pullup_i <= 16'($random(seed));
            pin_in_i <= 16'($random(seed));
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            chkv(pin_out_en_o, port_out_en_i & ~{w, v});
            chkv(pin_pullup_o, port_pullup_i & ~{w, v});
            chkv(port_in_o, pin_in_i & ~{w, v});
        end
        wr(OFS_CONFIG, 8'h00);
        conv(12'h0a5);
        rd(OFS_RESULT_HIGH, 8'h00);
        conv(12'h05a);
        rd(OFS_RESULT_LOW, 8'h5a);
        wr(OFS_CONFIG, 8'h04);
        rd(OFS_RESULT_LOW, 8'h00);
        conv(12'habc);
        rd(OFS_RESULT_HIGH, 8'h0a);
        conv(12'h123);
        rd(OFS_RESULT_LOW, 8'hbc);
        chkv(16'(rs_cnt), 16'h0001);
        conv(12'h456);
        rd(OFS_RESULT_HIGH, 8'h04);
        rd(OFS_RESULT_LOW, 8'h56);
        compare_function_enable_i <= 1'b1;
        compare_greater_i <= 1'b1;
        wr(OFS_CMP_HIGH, 8'h01);
        wr(OFS_CMP_LOW, 8'h00);
        conv(12'h0ff);
        conv(12'h345);
        rd(OFS_RESULT_HIGH, 8'h02);
        rd(OFS_RESULT_LOW, 8'h45);
        wr(OFS_CONFIG, 8'h08);
        wr(OFS_CMP_HIGH, 8'hfd);
        conv(12'h180);
        rd(OFS_RESULT_HIGH, 8'h00);
        rd(OFS_RESULT_LOW, 8'h80);
        wr(OFS_CONFIG, 8'h00);
        wr(OFS_CMP_HIGH, 8'hff);
        wr(OFS_CMP_LOW, 8'h10);
        conv(12'h030);
        rd(OFS_RESULT_LOW, 8'h20);
        rd(OFS_CMP_HIGH, 8'hff);
        // Less-than compare, then a single-mode miss and a hit while blocked
        compare_greater_i <= 1'b0;
        conv(12'h005);
        rd(OFS_RESULT_LOW, 8'hf5);
        wr(OFS_CONFIG, 8'h04);
        single_mode_i <= 1'b1;
        conv(12'h100);
        rd(OFS_RESULT_HIGH, 8'h01);
        conv(12'hf20);
        conv(12'h200);
        rd(OFS_RESULT_LOW, 8'hf0);
        chkv(16'(rs_cnt), 16'h0002);
        repeat (3) @(posedge clk_i);
        chkv(16'(st_cnt), 16'h0009);
        stop_test();
    end
endmodule
